/* bench/ipb_prio_bank_chk.sv */
// ipb_prio_bank_chk: apb and field output assertions
// assumes a bind to ipb_prio_bank, sees its ports only
`timescale 1ns/1ns
`default_nettype none
module ipb_prio_bank_chk
(
  input wire logic        CLK_I,
  input wire logic        RESET_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0]  PSTRB_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic [2:0]  CAN1_EVENT_PRIO_O,
  input wire logic [27:0] SOURCE_ENABLE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  sequence s_wr;
    PSEL_I && PENABLE_I && PWRITE_I;
  endsequence
  sequence s_rd;
    PSEL_I && PENABLE_I && !PWRITE_I;
  endsequence
  a_ready_high: assert property (PREADY_O) else $error("ready low");
  a_wr_top: assert property (s_wr ##0 (PADDR_I == 8'h00 && PSTRB_I[1])
    |=> CAN1_EVENT_PRIO_O == $past(PWDATA_I[14:12])) else $error("no write");
  a_hold_field: assert property (!(PSEL_I && PENABLE_I && PWRITE_I)
    |=> $stable(CAN1_EVENT_PRIO_O)) else $error("field moved");
  a_en_first: assert property (SOURCE_ENABLE_O[0] ==
    (CAN1_EVENT_PRIO_O != 3'h0)) else $error("enable wrong");
  a_rd_gaps: assert property (s_rd ##0 PADDR_I < 8'h1C |->
    (PRDATA_O & 32'hFFFF8888) == 32'h0) else $error("gap bit set");
  a_err_unmap: assert property (PSEL_I && PENABLE_I && PADDR_I > 8'h1C
    |-> PSLVERR_O) else $error("no error");
  a_err_mapped: assert property (s_rd ##0 PADDR_I < 8'h1C |-> !PSLVERR_O)
    else $error("false error");
  a_rst_value: assert property ($fell(RESET_I) |->
    CAN1_EVENT_PRIO_O == 3'h4) else $error("bad reset value");
endmodule
bind ipb_prio_bank ipb_prio_bank_chk u_chk (.*);
`default_nettype wire

/* bench/ipb_prio_bank_tb.sv */
// ipb_prio_bank_tb: apb register and field output tests
// assumes package, design and checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module ipb_prio_bank_tb
  import ipb_pkg::*;
;
  logic        CLK_I = 1'b0, RESET_I = 1'b1, PSEL_I = 1'b0;
  logic        PENABLE_I = 1'b0, PWRITE_I = 1'b0, er;
  logic [7:0]  PADDR_I = 8'h00;
  logic [31:0] PWDATA_I = 32'h0, rd;
  logic [3:0]  PSTRB_I = 4'h0;
  logic [15:0] m [7];
  wire  [31:0] PRDATA_O;
  wire         PREADY_O, PSLVERR_O;
  wire  [27:0] en;
  wire  [2:0]  f [28];
  int          n_fail = 0, tests_run = 0, cyc = 0;
  localparam logic [15:0] IPB_PATS [4] = '{16'hFFFF, 16'h0000, 16'h1111,
                                           16'hA5C3};
  ipb_prio_bank u_dut (.*, .SOURCE_ENABLE_O(en),
    .CAN1_EVENT_PRIO_O(f[0]), .CAN1_RX_READY_PRIO_O(f[1]),
    .SPI2_EVENT_PRIO_O(f[2]), .SPI2_ERROR_PRIO_O(f[3]),
    .CAPTURE5_PRIO_O(f[4]), .CAPTURE4_PRIO_O(f[5]), .CAPTURE3_PRIO_O(f[6]),
    .DMA_CH3_DONE_PRIO_O(f[7]), .COMPARE7_PRIO_O(f[8]),
    .COMPARE6_PRIO_O(f[9]), .COMPARE5_PRIO_O(f[10]),
    .CAPTURE6_PRIO_O(f[11]), .TIMER6_PRIO_O(f[12]),
    .DMA_CH4_DONE_PRIO_O(f[13]), .PARALLEL_PORT_PRIO_O(f[14]),
    .COMPARE8_PRIO_O(f[15]), .TIMER8_PRIO_O(f[16]),
    .I2C2_MASTER_PRIO_O(f[17]), .I2C2_SLAVE_PRIO_O(f[18]),
    .TIMER7_PRIO_O(f[19]), .CAN2_RX_READY_PRIO_O(f[20]),
    .EXT_IRQ4_PRIO_O(f[21]), .EXT_IRQ3_PRIO_O(f[22]), .TIMER9_PRIO_O(f[23]),
    .CODEC_IF_ERROR_PRIO_O(f[24]), .QUAD_DECODER1_PRIO_O(f[25]),
    .PWM_SPECIAL_MATCH_PRIO_O(f[26]), .CAN2_EVENT_PRIO_O(f[27]));
  initial forever #25 CLK_I = ~CLK_I;
  always @(posedge CLK_I)
    if (++cyc > 5000)
    begin
      n_fail++;
      report_and_stop;
    end
  function automatic logic [15:0] nxt(logic [15:0] o, logic [31:0] d,
                                      logic [3:0] s);
    if (s[0]) o[7:0] = d[7:0];
    if (s[1]) o[15:8] = d[15:8];
    return o & IPB_IMPL_MASK;
  endfunction
  function automatic logic [2:0] fe(int k);
    return 3'(m[k/4] >> (12 - 4*(k%4)));
  endfunction
  function automatic logic [31:0] lv();
    logic [2:0] h;
    logic       t;
    h = 3'h0;
    t = 1'b0;
    for (int k = 0; k < 28; k++)
    begin
      if (fe(k) > h) h = fe(k);
      if (fe(k) == 3'h7) t = 1'b1;
    end
    return {28'h0000000, t, h};
  endfunction
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    PSTRB_I <= w ? s : 4'h0;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    do @(posedge CLK_I); while (PREADY_O !== 1'b1);
    rd = PRDATA_O;
    er = PSLVERR_O;
    PENABLE_I <= 1'b0;
  endtask
  task automatic idle;
    PSEL_I <= 1'b0;
    @(posedge CLK_I);
  endtask
  task automatic cmp(logic [31:0] g, logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(int r, logic [31:0] d, logic [3:0] s);
    apb(1'b1, 8'(4*r), d, s);
    m[r] = nxt(m[r], d, s);
  endtask
  task automatic chk(string t);
    for (int r = 0; r < 7; r++)
    begin
      apb(1'b0, 8'(4*r), 32'h0, 4'h0);
      cmp(rd, {16'h0, m[r]});
    end
    apb(1'b0, IPB_OFF_LEVEL, 32'h0, 4'h0);
    cmp(rd, lv());
    idle;
    for (int k = 0; k < 28; k++)
    begin
      cmp(32'(f[k]), 32'(fe(k)));
      cmp(32'(en[k]), 32'(fe(k) != 3'h0));
    end
    $display("test %s done", t);
  endtask
  task automatic rst;
    RESET_I <= 1'b1;
    repeat (8) @(posedge CLK_I);
    RESET_I <= 1'b0;
    foreach (m[r]) m[r] = IPB_REG_RST;
    @(posedge CLK_I);
    chk("reset");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(34543));
    rst;
    foreach (IPB_PATS[i])
    begin
      for (int r = 0; r < 7; r++) wr(r, IPB_PATS[i], 4'h3);
      idle;
      chk("pattern");
    end
    for (int i = 0; i < 40; i++) wr($urandom % 7, $urandom, 4'($urandom));
    idle;
    chk("random");
    apb(1'b1, 8'h20, 32'hFFFF, 4'h3);
    cmp(32'(er), 32'h1);
    apb(1'b0, 8'h24, 32'h0, 4'h0);
    cmp(rd, 32'h0);
    apb(1'b1, IPB_OFF_LEVEL, 32'hFFFF, 4'h3);
    cmp(32'(er), 32'h1);
    idle;
    chk("refused");
    rst;
    report_and_stop;
  end
endmodule
`default_nettype wire

/* design/ipb_level_decode.sv */
// ipb_level_decode: turns one 3-bit priority field into level and enable
// assumes field values come straight from the register bank
`timescale 1ns/1ns
`default_nettype none

module ipb_level_decode
  import ipb_pkg::*;
(
  input  wire logic [2:0] field_i,
  output logic            enable_o,
  output logic            top_o,
  output logic [2:0]      level_o
);

  assign enable_o = (field_i != IPB_PRIO_OFF);
  assign top_o    = (field_i == IPB_PRIO_MAX);
  assign level_o  = field_i;

endmodule

`default_nettype wire

/* design/ipb_prio_bank.sv */
// ipb_prio_bank: seven interrupt priority registers behind an apb slave
// assumes apb master on CLK_I, synchronous active-high RESET_I
//
// Function
// - code 111 gives priority seven, highest
// - code 001 lowest, codes map linearly
// - code 000 disables the source
// - bits 15, 11, 7, 3 read zero
// - every field resets to binary 100
// - reg 8: can1 event, can1 rx, spi2
// - reg 9: capture 5,4,3, dma ch3
// - reg 10: compare 7,6,5, capture 6
// - reg 11: timer6, dma4, parallel, compare8
// - reg 12: timer8, i2c2 master/slave, timer7
// - reg 13: can2 rx, ext 4,3, timer9
// - reg 14: codec err, quad, pwm, can2
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module ipb_prio_bank
  import ipb_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic [2:0]       CAN1_EVENT_PRIO_O,
  output logic [2:0]       CAN1_RX_READY_PRIO_O,
  output logic [2:0]       SPI2_EVENT_PRIO_O,
  output logic [2:0]       SPI2_ERROR_PRIO_O,
  output logic [2:0]       CAPTURE5_PRIO_O,
  output logic [2:0]       CAPTURE4_PRIO_O,
  output logic [2:0]       CAPTURE3_PRIO_O,
  output logic [2:0]       DMA_CH3_DONE_PRIO_O,
  output logic [2:0]       COMPARE7_PRIO_O,
  output logic [2:0]       COMPARE6_PRIO_O,
  output logic [2:0]       COMPARE5_PRIO_O,
  output logic [2:0]       CAPTURE6_PRIO_O,
  output logic [2:0]       TIMER6_PRIO_O,
  output logic [2:0]       DMA_CH4_DONE_PRIO_O,
  output logic [2:0]       PARALLEL_PORT_PRIO_O,
  output logic [2:0]       COMPARE8_PRIO_O,
  output logic [2:0]       TIMER8_PRIO_O,
  output logic [2:0]       I2C2_MASTER_PRIO_O,
  output logic [2:0]       I2C2_SLAVE_PRIO_O,
  output logic [2:0]       TIMER7_PRIO_O,
  output logic [2:0]       CAN2_RX_READY_PRIO_O,
  output logic [2:0]       EXT_IRQ4_PRIO_O,
  output logic [2:0]       EXT_IRQ3_PRIO_O,
  output logic [2:0]       TIMER9_PRIO_O,
  output logic [2:0]       CODEC_IF_ERROR_PRIO_O,
  output logic [2:0]       QUAD_DECODER1_PRIO_O,
  output logic [2:0]       PWM_SPECIAL_MATCH_PRIO_O,
  output logic [2:0]       CAN2_EVENT_PRIO_O,
  output logic [27:0]      SOURCE_ENABLE_O
);

  localparam int NSRC = IPB_NUM_REGS * IPB_FIELDS;

  logic [15:0] prio_reg [IPB_NUM_REGS];
  logic [15:0] prio_next [IPB_NUM_REGS];
  logic [2:0]  field [NSRC];
  logic [2:0]  level [NSRC];
  logic        src_en [NSRC];
  logic        src_top [NSRC];
  logic [27:0] enable_vec;
  logic [27:0] top_vec;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        slverr_reg;
  logic        wr_access;
  logic        rd_access;
  logic        sel_valid;
  logic [2:0]  sel_idx;
  logic [15:0] wmask;
  logic [2:0]  high_level;

  // write lands on the access edge, when pready is sampled
  assign wr_access = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_access = PSEL_I & ~PENABLE_I & ~PWRITE_I;

  // address decode
  always_comb
  begin
    sel_valid = 1'b1;
    sel_idx   = 3'h0;
    if (PADDR_I == IPB_OFF_CTRL_8)
      sel_idx = 3'h0;
    else if (PADDR_I == IPB_OFF_CTRL_9)
      sel_idx = 3'h1;
    else if (PADDR_I == IPB_OFF_CTRL_10)
      sel_idx = 3'h2;
    else if (PADDR_I == IPB_OFF_CTRL_11)
      sel_idx = 3'h3;
    else if (PADDR_I == IPB_OFF_CTRL_12)
      sel_idx = 3'h4;
    else if (PADDR_I == IPB_OFF_CTRL_13)
      sel_idx = 3'h5;
    else if (PADDR_I == IPB_OFF_CTRL_14)
      sel_idx = 3'h6;
    else
      sel_valid = 1'b0;
  end

  // byte-lane mask, only implemented bits writable
  assign wmask = {{8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}} & IPB_IMPL_MASK;

  genvar g;
  generate
    for (g = 0; g < IPB_NUM_REGS; g++)
    begin : g_reg
      always_comb
      begin
        prio_next[g] = prio_reg[g];
        if (wr_access && sel_valid && sel_idx == 3'(g))
          prio_next[g] = (prio_reg[g] & ~wmask)
                       | (PWDATA_I[15:0] & wmask);
      end

      always_ff @(posedge CLK_I)
      begin
        if (RESET_I)
          prio_reg[g] <= IPB_REG_RST;
        else
          prio_next_store: prio_reg[g] <= prio_next[g] & IPB_IMPL_MASK;
      end
    end

    for (g = 0; g < NSRC; g++)
    begin : g_src
      localparam int R = g / IPB_FIELDS;
      localparam int F = (IPB_FIELDS - 1) - (g % IPB_FIELDS);
      assign field[g] = prio_reg[R][F*4 +: IPB_FIELD_W];
      ipb_level_decode u_dec
      (
        .field_i  (field[g]),
        .enable_o (src_en[g]),
        .top_o    (src_top[g]),
        .level_o  (level[g])
      );
      assign enable_vec[g] = src_en[g];
      assign top_vec[g]    = src_top[g];
    end
  endgenerate

  // highest level among all enabled sources
  always_comb
  begin
    high_level = IPB_PRIO_OFF;
    for (int i = 0; i < NSRC; i++)
      if (src_en[i] && level[i] > high_level)
        high_level = level[i];
  end

  // read mux, unused bits zero
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (rd_access)
    begin
      if (sel_valid)
        rdata_next = {16'h0000, prio_reg[sel_idx] & IPB_IMPL_MASK};
      else if (PADDR_I == IPB_OFF_LEVEL)
        rdata_next = {28'h0000000, |top_vec, high_level};
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
      rdata_reg <= 32'h0000_0000;
    else if (rd_access)
      rdata_reg <= rdata_next;
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
      slverr_reg <= 1'b0;
    else if (PSEL_I && !PENABLE_I)
      slverr_reg <= !sel_valid
                    && !(PADDR_I == IPB_OFF_LEVEL && !PWRITE_I);
  end

  assign PRDATA_O  = rdata_reg;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & slverr_reg;

  assign SOURCE_ENABLE_O = enable_vec;

  // field to source mapping
  assign CAN1_EVENT_PRIO_O        = field[0];
  assign CAN1_RX_READY_PRIO_O     = field[1];
  assign SPI2_EVENT_PRIO_O        = field[2];
  assign SPI2_ERROR_PRIO_O        = field[3];
  assign CAPTURE5_PRIO_O          = field[4];
  assign CAPTURE4_PRIO_O          = field[5];
  assign CAPTURE3_PRIO_O          = field[6];
  assign DMA_CH3_DONE_PRIO_O      = field[7];
  assign COMPARE7_PRIO_O          = field[8];
  assign COMPARE6_PRIO_O          = field[9];
  assign COMPARE5_PRIO_O          = field[10];
  assign CAPTURE6_PRIO_O          = field[11];
  assign TIMER6_PRIO_O            = field[12];
  assign DMA_CH4_DONE_PRIO_O      = field[13];
  assign PARALLEL_PORT_PRIO_O     = field[14];
  assign COMPARE8_PRIO_O          = field[15];
  assign TIMER8_PRIO_O            = field[16];
  assign I2C2_MASTER_PRIO_O       = field[17];
  assign I2C2_SLAVE_PRIO_O        = field[18];
  assign TIMER7_PRIO_O            = field[19];
  assign CAN2_RX_READY_PRIO_O     = field[20];
  assign EXT_IRQ4_PRIO_O          = field[21];
  assign EXT_IRQ3_PRIO_O          = field[22];
  assign TIMER9_PRIO_O            = field[23];
  assign CODEC_IF_ERROR_PRIO_O    = field[24];
  assign QUAD_DECODER1_PRIO_O     = field[25];
  assign PWM_SPECIAL_MATCH_PRIO_O = field[26];
  assign CAN2_EVENT_PRIO_O        = field[27];

endmodule

`default_nettype wire

/* include/ipb_pkg.sv */
// ipb_pkg: offsets, field layout and reset values of the priority bank
// assumes a 32-bit apb slave with one aligned word per register
package ipb_pkg;

  localparam int          IPB_NUM_REGS    = 7;
  localparam int          IPB_FIELDS      = 4;
  localparam int          IPB_FIELD_W     = 3;
  localparam int          IPB_REG_W       = 16;
  localparam int          IPB_ADDR_W      = 8;
  localparam int          IPB_FIRST_INDEX = 8;

  localparam logic [7:0]  IPB_OFF_CTRL_8  = 8'h00;
  localparam logic [7:0]  IPB_OFF_CTRL_9  = 8'h04;
  localparam logic [7:0]  IPB_OFF_CTRL_10 = 8'h08;
  localparam logic [7:0]  IPB_OFF_CTRL_11 = 8'h0C;
  localparam logic [7:0]  IPB_OFF_CTRL_12 = 8'h10;
  localparam logic [7:0]  IPB_OFF_CTRL_13 = 8'h14;
  localparam logic [7:0]  IPB_OFF_CTRL_14 = 8'h18;
  localparam logic [7:0]  IPB_OFF_LEVEL   = 8'h1C;

  localparam int          IPB_POS_F3      = 12;
  localparam int          IPB_POS_F2      = 8;
  localparam int          IPB_POS_F1      = 4;
  localparam int          IPB_POS_F0      = 0;

  localparam logic [15:0] IPB_IMPL_MASK   = 16'h7777;
  localparam logic [2:0]  IPB_FIELD_RST   = 3'h4;
  localparam logic [15:0] IPB_REG_RST     = 16'h4444;
  localparam logic [2:0]  IPB_PRIO_OFF    = 3'h0;
  localparam logic [2:0]  IPB_PRIO_MAX    = 3'h7;

endpackage
